//--- rtl/cms_cfg.svh
`ifndef CMS_CFG_SVH
`define CMS_CFG_SVH

// register offsets
`define CMS_OFS_CTRL    4'h0
`define CMS_OFS_STATUS  4'h4
// control fields
`define CMS_CTRL_SRC    0
`define CMS_CTRL_MON    1
// status fields
`define CMS_ST_ESTB     0
`define CMS_ST_ISTB     1
`define CMS_ST_EDEAD    2
`define CMS_ST_IDEAD    3
`define CMS_ST_SRC      4
`define CMS_ST_MON      5
// reset values
`define CMS_CTRL_RST    2'h0
// counts
`define CMS_LONG_W      12
`define CMS_STAB_SHORT  3
`define CMS_STAB_LONG   11
`define CMS_MISS_LIMIT  2'h2
`define CMS_MEAS_LIMIT  2'h2

`endif

//--- rtl/cms_pkg.sv
package cms_pkg;

  // loose configuration and enable inputs
  typedef struct packed {
    logic slow_crystal_select;
    logic crystal_amp_enable;
    logic ext_gen_enable;
    logic int_gen_enable;
    logic ext_clock_on;
  } cms_cfg_t;

  // pin control outputs
  typedef struct packed {
    logic crystal_amp_on;
    logic osc_out_port_oe_n;
    logic osc_in_port_oe_n;
  } cms_pin_t;

  typedef enum logic [1:0] {
    CMS_SW_RUN  = 2'b00,
    CMS_SW_OLD  = 2'b01,
    CMS_SW_LOW  = 2'b10
  } cms_sw_state_t;

endpackage : cms_pkg

//--- rtl/cms_clock_monitor.sv
// Function
// R1: crystal amplifier on only when generator enable and amplifier config both set.
// R2: with amplifier off, oscillator output pin returns to port use.
// R3: external clock input path enabled only with generator enable; else port pin.
// R4: references come from external clock and internal base clock, half rate or slower.
// R5: both clocks always divided by four; long divider on one per slow bit.
// R6: long divider doubles as stabilization counter, held reset without generator enable.
// R7: before stable, long divider counts external clock; tap at 16 or 4096.
// R8: falling stabilization clock sets external stable; divider then resumes reference role.
// R9: external clock death clears stable and reverts divider; software stops monitor.
// R10: internal dead after two reference lows without base edge; next edge clears.
// R11: internal stable set after two consecutive filter stable measurements.
// R12: internal stable cleared by filter unstable, generator off or internal dead.
// R13: external dead after two reference lows without clock edge; next edge clears.
// R14: external stable cleared by generator off or external dead.
// R15: oscillator output switch picks external when source select set, else internal.
// R16: source select changes only with both generators on and target stable; the R23 forced change skips this check.
// R17: timebase switch picks external when external clock on bit is set, unless an R21 force selects the live clock.
// R18: generator output clock is oscillator output clock divided by two.
// R19: switch runs old clock, holds low, then runs new clock, glitch-free.
// R20: during reset the switches select the internal clock.
// R21: monitor on with dead side forces immediate deselect, live clock follows.
// R22: monitor may be turned on only with both generators on and stable.
// R23: on a detected dead clock, source select shows the live clock; the code forces this only while the monitor is on.
// R24: normal mode long divider on external when slow bit clear, else base.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ns

// ***********************************
// glitch-free two-way clock switch
// ***********************************
module cms_clk_switch (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic clk_int,
  input  wire logic clk_ext,
  input  wire logic sel,
  input  wire logic kill_old,
  output logic      clk_o
);
  cms_pkg::cms_sw_state_t state_q;
  cms_pkg::cms_sw_state_t state_d;
  logic cur_q;
  logic cur_d;
  logic int_prev_q;
  logic ext_prev_q;
  logic out_q;
  logic out_d;
  wire  int_fall = int_prev_q & ~clk_int;
  wire  ext_fall = ext_prev_q & ~clk_ext;
  wire  old_fall = cur_q ? ext_fall : int_fall;
  wire  new_fall = cur_q ? int_fall : ext_fall;
  wire  cur_clk  = cur_q ? clk_ext : clk_int;

  always_comb
  begin
    state_d = state_q;
    cur_d   = cur_q;
    out_d   = 1'b0;
    case (state_q)
      cms_pkg::CMS_SW_RUN:
      begin
        out_d = cur_clk;
        if (sel != cur_q)
        begin
          state_d = kill_old ? cms_pkg::CMS_SW_LOW : cms_pkg::CMS_SW_OLD; // R21
          out_d   = kill_old ? 1'b0 : cur_clk;
        end
      end
      cms_pkg::CMS_SW_OLD:
      begin
        out_d = cur_clk; // R19
        if (old_fall || kill_old)
        begin
          state_d = cms_pkg::CMS_SW_LOW;
          out_d   = 1'b0;
        end
      end
      cms_pkg::CMS_SW_LOW:
      begin
        if (new_fall) // R19
        begin
          state_d = cms_pkg::CMS_SW_RUN;
          cur_d   = ~cur_q;
        end
      end
      default:
      begin
        state_d = cms_pkg::CMS_SW_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q    <= cms_pkg::CMS_SW_RUN;
      cur_q      <= 1'b0; // R20
      int_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
      out_q      <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      cur_q      <= cur_d;
      int_prev_q <= clk_int;
      ext_prev_q <= clk_ext;
      out_q      <= out_d;
    end
  end

  assign clk_o = out_q;
endmodule : cms_clk_switch

// ***********************************
// clock monitor and select top
// ***********************************
module cms_clock_monitor (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire cms_pkg::cms_cfg_t   cfg,
  input  wire logic                osc_in_port_pin,
  input  wire logic                int_clock,
  input  wire logic                int_base_clock,
  input  wire logic                loop_filter_stable,
  input  wire logic [3:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [7:0]               reg_rdata,
  output cms_pkg::cms_pin_t        pins,
  output logic                     osc_out_clock,
  output logic                     timebase_clock,
  output logic                     gen_out_clock
);
`include "cms_cfg.svh"

  // ***********************************
  // pins and external clock path
  // ***********************************
  wire ext_clock = osc_in_port_pin & cfg.ext_gen_enable; // R3

  assign pins.crystal_amp_on    = cfg.ext_gen_enable & cfg.crystal_amp_enable; // R1
  assign pins.osc_out_port_oe_n = cfg.ext_gen_enable & cfg.crystal_amp_enable; // R2
  assign pins.osc_in_port_oe_n  = cfg.ext_gen_enable; // R3

  // ***********************************
  // edge detection and divide by four
  // ***********************************
  logic       ext_clock_prev_q;
  logic       int_base_clock_prev_q;
  logic [1:0] ediv_q;
  logic [1:0] idiv_q;
  logic       ediv_prev_q;
  logic       idiv_prev_q;
  wire  ext_clock_fall  = ext_clock_prev_q & ~ext_clock;
  wire  int_base_clock_fall = int_base_clock_prev_q & ~int_base_clock;
  wire  ediv_fall  = ediv_prev_q & ~ediv_q[1];
  wire  idiv_fall  = idiv_prev_q & ~idiv_q[1];

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_clock_prev_q  <= 1'b0;
      int_base_clock_prev_q <= 1'b0;
      ediv_q       <= 2'h0;
      idiv_q       <= 2'h0;
      ediv_prev_q  <= 1'b0;
      idiv_prev_q  <= 1'b0;
    end
    else
    begin
      ext_clock_prev_q  <= ext_clock;
      int_base_clock_prev_q <= int_base_clock;
      ediv_q       <= ediv_q + {1'b0, ext_clock_fall}; // R5
      idiv_q       <= idiv_q + {1'b0, int_base_clock_fall}; // R5
      ediv_prev_q  <= ediv_q[1];
      idiv_prev_q  <= idiv_q[1];
    end
  end

  // ***********************************
  // long divider and stabilization
  // ***********************************
  logic [`CMS_LONG_W-1:0] long_q;
  logic                   stab_prev_q;
  logic                   ext_stable_q;
  logic                   ext_stable_d;
  logic                   ext_dead_q;
  logic                   int_dead_q;

  wire long_step = !ext_stable_q ? ext_clock_fall // R7
                 : (cfg.slow_crystal_select ? idiv_fall : ediv_fall); // R24
  wire stab_tap  = cfg.crystal_amp_enable ? long_q[`CMS_STAB_LONG]
                                          : long_q[`CMS_STAB_SHORT]; // R7
  wire stab_fall = stab_prev_q & ~stab_tap & ~ext_stable_q; // R8
  wire long_out  = long_q[`CMS_LONG_W-1];

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      long_q      <= '0;
      stab_prev_q <= 1'b0;
    end
    else if (!cfg.ext_gen_enable)
    begin
      long_q      <= '0; // R6
      stab_prev_q <= 1'b0;
    end
    else
    begin
      long_q      <= long_q + {{(`CMS_LONG_W-1){1'b0}}, long_step};
      stab_prev_q <= stab_tap;
    end
  end

  always_comb
  begin
    ext_stable_d = ext_stable_q;
    if (stab_fall)
      ext_stable_d = 1'b1; // R8
    if (!cfg.ext_gen_enable || ext_dead_q)
      ext_stable_d = 1'b0; // R14 R9
  end

  // ***********************************
  // references
  // ***********************************
  wire ext_ref = cfg.slow_crystal_select ? ediv_q[1] : long_out; // R4 R24
  wire int_ref = cfg.slow_crystal_select ? long_out : idiv_q[1]; // R4 R24
  logic ext_ref_prev_q;
  logic int_ref_prev_q;
  wire  ext_ref_rise = ~ext_ref_prev_q & ext_ref;
  wire  int_ref_rise = ~int_ref_prev_q & int_ref;

  // ***********************************
  // activity detectors
  // ***********************************
  logic       iseen_q;
  logic       eseen_q;
  logic [1:0] imiss_q;
  logic [1:0] emiss_q;
  logic [1:0] meas_q;
  logic       int_stable_q;
  wire  ihit = int_base_clock_fall & ~ext_ref;
  wire  ehit = ext_clock_fall & ~int_ref;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      ext_ref_prev_q <= 1'b0;
      int_ref_prev_q <= 1'b0;
      iseen_q        <= 1'b0;
      eseen_q        <= 1'b0;
      imiss_q        <= 2'h0;
      emiss_q        <= 2'h0;
      int_dead_q     <= 1'b0;
      ext_dead_q     <= 1'b0;
      meas_q         <= 2'h0;
      int_stable_q   <= 1'b0;
      ext_stable_q   <= 1'b0;
    end
    else
    begin
      ext_ref_prev_q <= ext_ref;
      int_ref_prev_q <= int_ref;
      ext_stable_q   <= ext_stable_d;
      // internal side
      if (ihit)
      begin
        iseen_q    <= 1'b1;
        imiss_q    <= 2'h0;
        int_dead_q <= 1'b0; // R10
      end
      else if (ext_ref_rise)
      begin
        iseen_q <= 1'b0;
        if (!iseen_q && imiss_q != `CMS_MISS_LIMIT)
          imiss_q <= imiss_q + 2'h1;
        if (!iseen_q && imiss_q == `CMS_MISS_LIMIT - 2'h1)
          int_dead_q <= 1'b1; // R10
      end
      // external side
      if (ehit)
      begin
        eseen_q    <= 1'b1;
        emiss_q    <= 2'h0;
        ext_dead_q <= 1'b0; // R13
      end
      else if (int_ref_rise)
      begin
        eseen_q <= 1'b0;
        if (!eseen_q && emiss_q != `CMS_MISS_LIMIT)
          emiss_q <= emiss_q + 2'h1;
        if (!eseen_q && emiss_q == `CMS_MISS_LIMIT - 2'h1)
          ext_dead_q <= 1'b1; // R13
      end
      // internal stable from filter measurements
      if (!loop_filter_stable || !cfg.int_gen_enable || int_dead_q)
      begin
        meas_q       <= 2'h0;
        int_stable_q <= 1'b0; // R12
      end
      else if (ext_ref_rise)
      begin
        if (meas_q != `CMS_MEAS_LIMIT)
          meas_q <= meas_q + 2'h1;
        if (meas_q == `CMS_MEAS_LIMIT - 2'h1)
          int_stable_q <= 1'b1; // R11
      end
    end
  end

  // ***********************************
  // register port
  // ***********************************
  logic src_sel_q;
  logic mon_on_q;
  logic [7:0] rdata_q;
  wire  both_on  = cfg.int_gen_enable & cfg.ext_gen_enable;
  wire  wr_ctrl  = reg_wr && reg_addr == `CMS_OFS_CTRL;
  wire  new_src  = reg_wdata[`CMS_CTRL_SRC];
  wire  src_ok   = both_on && (new_src ? ext_stable_q : int_stable_q); // R16
  wire  mon_ok   = both_on && ext_stable_q && int_stable_q; // R22
  wire  force_i  = mon_on_q & ext_dead_q;
  wire  force_e  = mon_on_q & int_dead_q & ~ext_dead_q;
  wire  rd_ctrl  = reg_addr == `CMS_OFS_CTRL;
  wire  rd_stat  = reg_addr == `CMS_OFS_STATUS;
  wire [7:0] ctrl_rd = {6'h00, mon_on_q, src_sel_q};
  wire [7:0] stat_rd = {2'h0, mon_on_q, src_sel_q, int_dead_q,
                        ext_dead_q, int_stable_q, ext_stable_q};
  wire [7:0] rd_mux  = rd_ctrl ? ctrl_rd : (rd_stat ? stat_rd : 8'h00);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      src_sel_q <= 1'(`CMS_CTRL_RST >> `CMS_CTRL_SRC);
      mon_on_q  <= 1'b0;
      rdata_q   <= 8'h00;
    end
    else
    begin
      if (force_i)
        src_sel_q <= 1'b0; // R23
      else if (force_e)
        src_sel_q <= 1'b1; // R23
      else if (wr_ctrl && src_ok)
        src_sel_q <= new_src; // R16
      if (wr_ctrl && (!reg_wdata[`CMS_CTRL_MON] || mon_ok))
        mon_on_q <= reg_wdata[`CMS_CTRL_MON]; // R22 R9
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ***********************************
  // clock selection
  // ***********************************
  wire osc_sel = src_sel_q; // R15
  wire tb_sel  = force_i ? 1'b0 : (force_e ? 1'b1 : cfg.ext_clock_on); // R17 R21

  cms_clk_switch u_osc_sw (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .clk_int  (int_clock),
    .clk_ext  (ext_clock),
    .sel      (osc_sel),
    .kill_old (force_i | force_e), // R21
    .clk_o    (osc_out_clock)
  );

  cms_clk_switch u_tb_sw (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .clk_int  (int_clock),
    .clk_ext  (ext_clock),
    .sel      (tb_sel),
    .kill_old (force_i | force_e), // R21
    .clk_o    (timebase_clock)
  );

  // ***********************************
  // generator output divide by two
  // ***********************************
  logic osc_prev_q;
  logic gen_q;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      osc_prev_q <= 1'b0;
      gen_q      <= 1'b0;
    end
    else
    begin
      osc_prev_q <= osc_out_clock;
      if (osc_prev_q && !osc_out_clock)
        gen_q <= ~gen_q; // R18
    end
  end

  assign gen_out_clock = gen_q;
endmodule : cms_clock_monitor

//--- test/cms_chk.sv
`timescale 1ns/1ns
`include "cms_cfg.svh"
// ****************
// port checker
// ****************
module cms_chk (
  input wire logic              clk_sys,
  input wire logic              nrst,
  input wire cms_pkg::cms_cfg_t cfg,
  input wire logic              int_clock,
  input wire logic [3:0]        reg_addr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_rdata,
  input wire cms_pkg::cms_pin_t pins,
  input wire logic              osc_out_clock,
  input wire logic              timebase_clock,
  input wire logic              gen_out_clock
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  amp_pin_a: assert property (
    pins.crystal_amp_on == (cfg.ext_gen_enable && cfg.crystal_amp_enable))
    else $error("amplifier enable wrong");
  out_pin_use_a: assert property (
    pins.osc_out_port_oe_n == (cfg.ext_gen_enable && cfg.crystal_amp_enable))
    else $error("output pin use wrong");
  in_pin_use_a: assert property (
    pins.osc_in_port_oe_n == cfg.ext_gen_enable)
    else $error("input pin use wrong");
  bus_clk_hold_a: assert property (
    $stable(osc_out_clock) [*4] |-> $stable(gen_out_clock))
    else $error("bus clock moved without source");
  bus_clk_step_a: assert property (
    $fell(osc_out_clock) |-> ##[0:2] $changed(gen_out_clock))
    else $error("bus clock missed a fall");
  timebase_int_a: assert property (
    (!cfg.ext_clock_on) [*8] ##1 (!cfg.ext_clock_on && $stable(int_clock)) [*4]
    |-> $stable(timebase_clock))
    else $error("timebase moved on a still clock");
  int_stb_off_a: assert property (
    (!cfg.int_gen_enable) [*3] ##1
    (!cfg.int_gen_enable && reg_rd && reg_addr == `CMS_OFS_STATUS)
    |=> !reg_rdata[`CMS_ST_ISTB])
    else $error("internal stable while off");
  ext_stb_off_a: assert property (
    (!cfg.ext_gen_enable) [*3] ##1
    (!cfg.ext_gen_enable && reg_rd && reg_addr == `CMS_OFS_STATUS)
    |=> !reg_rdata[`CMS_ST_ESTB])
    else $error("external stable while off");
  live_sel_a: assert property (
    reg_rd && reg_addr == `CMS_OFS_STATUS ##1
    (reg_rdata[`CMS_ST_IDEAD] && reg_rdata[`CMS_ST_MON] && !reg_rdata[`CMS_ST_EDEAD])
    |-> reg_rdata[`CMS_ST_SRC])
    else $error("dead internal clock still selected");
endmodule : cms_chk

bind cms_clock_monitor cms_chk chk_u (
  .clk_sys(clk_sys), .nrst(nrst), .cfg(cfg), .int_clock(int_clock),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins),
  .osc_out_clock(osc_out_clock), .timebase_clock(timebase_clock),
  .gen_out_clock(gen_out_clock)
);

//--- test/cms_xtal_model.sv
`timescale 1ns/1ns
// ****************
// external clock source
// ****************
module cms_xtal_model #(
  parameter int HALF = 2
) (
  input  wire logic clk_sys,
  input  wire logic run,
  output logic      osc_in_port_pin = 1'b0
);
  int cnt_q = 0;

  // source stoppable by run; half period in system cycles sets the rate
  always @(posedge clk_sys)
  begin
    if (!run)
      cnt_q <= cnt_q;
    else if (cnt_q == HALF - 1)
    begin
      cnt_q <= 0;
      osc_in_port_pin <= ~osc_in_port_pin;
    end
    else
      cnt_q <= cnt_q + 1;
  end
endmodule : cms_xtal_model

//--- test/tb_top.sv
`timescale 1ns/1ns
`include "cms_cfg.svh"
// ****************
// bench
// ****************
module tb_top;
  logic              clk_sys = 1'b0;
  logic              nrst = 1'b0;
  cms_pkg::cms_cfg_t cfg = '0;
  logic              int_clock = 1'b0;
  logic              int_base_clock = 1'b0;
  logic              loop_filter_stable = 1'b0;
  logic              int_run = 1'b1;
  logic              base_run = 1'b1;
  logic              ext_run = 1'b1;
  logic [3:0]        reg_addr = 4'h0;
  logic [7:0]        reg_wdata = 8'h00;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [7:0]        reg_rdata;
  cms_pkg::cms_pin_t pins;
  logic              osc_in_port_pin;
  logic              osc_out_clock;
  logic              timebase_clock;
  logic              gen_out_clock;
  int                mismatches = 0;
  int                n_checks = 0;

  always #4 clk_sys = ~clk_sys;
  // stoppable internal clocks fake a dead source
  always @(posedge clk_sys)
  begin
    if (int_run) int_clock <= ~int_clock;
    if (base_run) int_base_clock <= ~int_base_clock;
  end

  cms_xtal_model #(.HALF(2)) xtal_u (
    .clk_sys(clk_sys), .run(ext_run), .osc_in_port_pin(osc_in_port_pin)
  );
  cms_clock_monitor dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .cfg(cfg), .osc_in_port_pin(osc_in_port_pin),
    .int_clock(int_clock), .int_base_clock(int_base_clock),
    .loop_filter_stable(loop_filter_stable), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins),
    .osc_out_clock(osc_out_clock), .timebase_clock(timebase_clock),
    .gen_out_clock(gen_out_clock)
  );

  // ****************
  // helpers
  // ****************
  task automatic chk(input string w, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    cyc(1);
    reg_wr <= 1'b0;
    cyc(1);
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
                       input string w);
    reg_addr <= a;
    reg_rd <= 1'b1;
    cyc(1);
    reg_rd <= 1'b0;
    cyc(1);
    chk(w, reg_rdata & m, e);
  endtask : rdchk

  // rising edges in 64 cycles of osc out, timebase and bus clock
  task automatic rates(input int eo, input int et, input int eg);
    int         e [3];
    int         r [3];
    logic [2:0] p;
    logic [2:0] v;
    e = '{eo, et, eg};
    r = '{0, 0, 0};
    p = {gen_out_clock, timebase_clock, osc_out_clock};
    repeat (64)
    begin
      @(posedge clk_sys);
      v = {gen_out_clock, timebase_clock, osc_out_clock};
      for (int i = 0; i < 3; i++) r[i] += int'(v[i] && !p[i]);
      p = v;
    end
    for (int i = 0; i < 3; i++) chk($sformatf("rises %0d", i),
                                    8'(r[i] >= e[i] - 1 && r[i] <= e[i] + 1), 8'h01);
  endtask : rates

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // ****************
  // scenarios
  // ****************
  task automatic after_reset;
    rdchk(`CMS_OFS_STATUS, 8'hFF, 8'h00, "status");
    rdchk(`CMS_OFS_CTRL, 8'hFF, 8'h00, "ctrl");
    rdchk(4'hC, 8'hFF, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++)
    begin
      cfg.ext_gen_enable <= i[0];
      cfg.crystal_amp_enable <= i[1];
      cyc(2);
      chk("amp", pins.crystal_amp_on, i[0] & i[1]);
      chk("out oe_n", pins.osc_out_port_oe_n, i[0] & i[1]);
      chk("in oe_n", pins.osc_in_port_oe_n, i[0]);
    end
    cfg.ext_gen_enable <= 1'b0;
    cfg.crystal_amp_enable <= 1'b0;
    rates(32, 32, 16);
    int_run <= 1'b0;
    cyc(20);
    int_run <= 1'b1;
    wr(`CMS_OFS_CTRL, 8'h03);
    rdchk(`CMS_OFS_CTRL, 8'h03, 8'h00, "early ctrl");
  endtask : after_reset

  task automatic ext_stabilize;
    for (int k = 0; k < 2; k++)
    begin
      cfg.ext_gen_enable <= 1'b1;
      cyc(44);
      rdchk(`CMS_OFS_STATUS, 8'h01, 8'h00, "ext early");
      cyc(30);
      rdchk(`CMS_OFS_STATUS, 8'h01, 8'h01, "ext stable");
      if (k == 0) cfg.ext_gen_enable <= 1'b0;
      cyc(3);
      rdchk(`CMS_OFS_STATUS, 8'h01, {7'h0, k[0]}, "ext off");
    end
  endtask : ext_stabilize

  task automatic int_stable;
    cyc(40);
    rdchk(`CMS_OFS_STATUS, 8'h02, 8'h00, "no filter");
    loop_filter_stable <= 1'b1;
    cyc(8);
    rdchk(`CMS_OFS_STATUS, 8'h02, 8'h00, "one measure");
    cyc(40);
    rdchk(`CMS_OFS_STATUS, 8'h02, 8'h02, "int stable");
    cfg.int_gen_enable <= 1'b0;
    cyc(3);
    rdchk(`CMS_OFS_STATUS, 8'h02, 8'h00, "int off");
    cfg.int_gen_enable <= 1'b1;
    loop_filter_stable <= 1'b0;
    cyc(40);
    rdchk(`CMS_OFS_STATUS, 8'h02, 8'h00, "filter low");
    loop_filter_stable <= 1'b1;
    cyc(40);
    rdchk(`CMS_OFS_STATUS, 8'h02, 8'h02, "int again");
  endtask : int_stable

  task automatic select_switch;
    cfg.ext_clock_on <= 1'b1;
    wr(`CMS_OFS_CTRL, 8'h01);
    rdchk(`CMS_OFS_CTRL, 8'h03, 8'h01, "select ext");
    cyc(16);
    rates(16, 16, 8);
    cfg.ext_clock_on <= 1'b0;
    cyc(16);
    rates(16, 32, 8);
    cfg.ext_clock_on <= 1'b1;
    wr(`CMS_OFS_CTRL, 8'h00);
    cyc(16);
    rates(32, 16, 16);
  endtask : select_switch

  task automatic monitor_dead;
    wr(`CMS_OFS_CTRL, 8'h02);
    rdchk(`CMS_OFS_CTRL, 8'h03, 8'h02, "monitor on");
    base_run <= 1'b0;
    cyc(64);
    rdchk(`CMS_OFS_STATUS, 8'h3F, 8'h39, "int dead");
    rates(16, 16, 8);
    base_run <= 1'b1;
    cyc(40);
    rdchk(`CMS_OFS_STATUS, 8'h08, 8'h00, "dead clear");
    wr(`CMS_OFS_CTRL, 8'h01);
    rdchk(`CMS_OFS_CTRL, 8'h03, 8'h01, "monitor off");
  endtask : monitor_dead

  // normal mode, external clock stops with monitor on
  task automatic ext_dead_mon;
    cyc(40);
    cfg.slow_crystal_select <= 1'b0;
    wr(`CMS_OFS_CTRL, 8'h03);
    rdchk(`CMS_OFS_CTRL, 8'h03, 8'h03, "monitor on ext");
    ext_run <= 1'b0;
    cyc(40);
    rdchk(`CMS_OFS_STATUS, 8'h3F, 8'h26, "ext dead");
    rates(32, 32, 16);
    wr(`CMS_OFS_CTRL, 8'h00);
    ext_run <= 1'b1;
    cyc(80);
    rdchk(`CMS_OFS_STATUS, 8'h3F, 8'h03, "ext again");
  endtask : ext_dead_mon

  initial
  begin
    #40000;
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    cyc(12);
    nrst <= 1'b1;
    cyc(1);
    cfg.slow_crystal_select <= 1'b1;
    cfg.int_gen_enable <= 1'b1;
    after_reset();
    ext_stabilize();
    int_stable();
    select_switch();
    monitor_dead();
    ext_dead_mon();
    report_and_stop();
  end
endmodule : tb_top
